// ### ccdc_regs.vh
// Purpose: register map, field positions and counts of the card controller
// Assumes: included by ccdc_top.v and by the checker and bench files
// Notes: ranges are given as msb:lsb for use inside a part-select
`ifndef CCDC_REGS_VH
`define CCDC_REGS_VH

// register offsets (byte addresses)
`define CCDC_A_CR     8'h00
`define CCDC_A_MR     8'h04
`define CCDC_A_SDCR   8'h0c
`define CCDC_A_ARGR   8'h10
`define CCDC_A_CMDR   8'h14
`define CCDC_A_BLKR   8'h18
`define CCDC_A_RSP0   8'h20
`define CCDC_A_RSP1   8'h24
`define CCDC_A_RSP2   8'h28
`define CCDC_A_RSP3   8'h2c
`define CCDC_A_RDR    8'h30
`define CCDC_A_TDR    8'h34
`define CCDC_A_SR     8'h40

// control register bits
`define CCDC_CR_EN    0
`define CCDC_CR_DIS   1
`define CCDC_CR_PSEN  2
`define CCDC_CR_PSDIS 3
`define CCDC_CR_SWRST 7

// mode register fields, then bus width and block register fields
`define CCDC_MR_DIV   7:0
`define CCDC_MR_PSDIV 10:8
`define CCDC_MR_RDG   11
`define CCDC_MR_WRG   12
`define CCDC_MR_BYTE  13
`define CCDC_MR_DMA   15
`define CCDC_MR_BLEN  31:16
`define CCDC_MR_RST   32'h00000000
`define CCDC_SDCR_WIDE 0
`define CCDC_BLK_CNT  15:0
`define CCDC_BLK_LEN  31:16

// command register fields
`define CCDC_C_IDX    5:0
`define CCDC_C_RSP    7:6
`define CCDC_C_OD     11
`define CCDC_C_LAT    12
`define CCDC_C_TRC    17:16
`define CCDC_C_TDIR   18
`define CCDC_C_TTYP   20:19
`define CCDC_RSP_NONE 2'd0
`define CCDC_RSP_136  2'd2
`define CCDC_TRC_GO   2'd1
`define CCDC_TRC_STOP 2'd2
`define CCDC_TT_ONE   2'd0
`define CCDC_TT_STRM  2'd2

// status register bits
`define CCDC_SR_CDONE 0
`define CCDC_SR_RXRDY 1
`define CCDC_SR_TXRDY 2
`define CCDC_SR_DIDLE 4
`define CCDC_SR_XDONE 5
`define CCDC_SR_RTO   16
`define CCDC_SR_RCE   17
`define CCDC_SR_DCE   18

// bit counts, in card clock cycles, and CRC polynomials
`define CCDC_LAT_STD  7'd5
`define CCDC_LAT_LONG 7'd64
`define CCDC_CMD_CRC  8'd40
`define CCDC_CMD_END  8'd47
`define CCDC_CMD_LEN  8'd48
`define CCDC_R48_LEN  8'd48
`define CCDC_R136_LEN 8'd136
`define CCDC_R136_LO  8'd8
`define CCDC_R136_HI  8'd128
`define CCDC_CRC16_N  5'd16
`define CCDC_BUSY_GAP 5'd8
`define CCDC_CRC7_P   7'h09
`define CCDC_CRC16_P  16'h1021

`endif

// ### ccdc_top.v
// Purpose: card bus command/response and data transfer controller
// Assumes: register port and card inputs synchronous to REF_CLK
// Notes: card clock made from REF_CLK; card bits move on its edges
//
// Contract
// - host sends each command bit-serially on command line
// - all bus bits move with the card clock
// - stream runs until a stop command
// - each data block followed by its CRC
// - disabled after reset until enable bit set
// - power save divides idle clock by 2^p+1
// - guard bits halt clock when receive buffer full or transmit buffer empty
// - command and response bits launched on rising edge
// - command line open-drain or push-pull per command
// - command starts at once on command register write
// - command done flag set when command completes
// - capture 48 or 136 bit responses
// - response kind 2 means 136-bit response
// - latency field 0 means five cycle limit
// - transfer field 0 means no data transfer
// - transfer type picks single, multi or stream
// - DMA mode services data through DMA requests
// - block length field sets block size
// - DMA units are words, or bytes in byte mode
// - block count 0 open-ended, else fixed count
// - counted multi-block ends itself after last block
// - bus width bit selects one or four lines
//
// Added by the designer: the address-and-strobe port and the register offsets.
`include "ccdc_regs.vh"
module ccdc_top (
	// system
	input  wire        REF_CLK,
	input  wire        RST_B,
	// register port
	input  wire [7:0]  REG_ADDR,
	input  wire [31:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [31:0] REG_RDATA,
	// card bus
	output reg         CARD_CLK,
	input  wire        CMD_IN,
	output reg         CMD_OUT,
	output reg         CMD_OE,
	input  wire [3:0]  DAT_IN,
	output reg  [3:0]  DAT_OUT,
	output reg  [3:0]  DAT_OE,
	// dma requests
	output reg         DMA_RX_REQ,
	output reg         DMA_TX_REQ
);
	localparam C_IDLE = 2'd0;
	localparam C_TX   = 2'd1;
	localparam C_WAIT = 2'd2;
	localparam C_RX   = 2'd3;
	localparam D_IDLE = 3'd0;
	localparam D_WAIT = 3'd1;
	localparam D_RX   = 3'd2;
	localparam D_RCRC = 3'd3;
	localparam D_TXS  = 3'd4;
	localparam D_TX   = 3'd5;
	localparam D_TCRC = 3'd6;
	localparam D_BUSY = 3'd7;

	function [6:0] crc7;
		input [6:0] c;
		input       b;
		begin
			crc7 = {c[5:0], 1'b0} ^ ({7{c[6] ^ b}} & `CCDC_CRC7_P);
		end
	endfunction

	function [15:0] crc16;
		input [15:0] c;
		input        b;
		begin
			crc16 = {c[14:0], 1'b0} ^ ({16{c[15] ^ b}} & `CCDC_CRC16_P);
		end
	endfunction

	reg         en_r, pws_r, sdw_r;
	reg [31:0]  mr_r, arg_r;
	reg [15:0]  block_count_field_r;
	reg [7:0]   hc_r, ps_r;
	reg         rise_r, fall_r;
	reg [1:0]   cst_r;
	reg [20:0]  cmd_r;
	reg [47:0]  tsh_r;
	reg [7:0]   cc_r;
	reg [6:0]   c7_r, lat_r;
	reg [135:0] rsh_r;
	reg [127:0] rsp_r;
	reg         done_r, rto_r, rce_r, cfin_r;
	reg [2:0]   dst_r;
	reg [19:0]  bc_r;
	reg [5:0]   ub_r;
	reg [15:0]  nb_r;
	reg [4:0]   dc_r;
	reg [31:0]  dsh_r, rdr_r, tdr_r;
	reg         rx_full_r, tx_full_r, xdone_r, dce_r;
	reg [31:0]  rd_v, sr_v;
	wire [3:0]  cz, cm;

	wire wr_cr  = REG_WR & (REG_ADDR == `CCDC_A_CR);
	wire rst    = ~RST_B | (wr_cr & REG_WDATA[`CCDC_CR_SWRST]);
	wire cmd_go = REG_WR & (REG_ADDR == `CCDC_A_CMDR) & en_r
		& (cst_r == C_IDLE);
	wire sr_rd  = REG_RD & (REG_ADDR == `CCDC_A_SR);
	wire rd_rdr = REG_RD & (REG_ADDR == `CCDC_A_RDR);
	wire wr_tdr = REG_WR & (REG_ADDR == `CCDC_A_TDR);
	wire idle   = (cst_r == C_IDLE) & (dst_r == D_IDLE);

	// data path geometry
	wire        byte_m = mr_r[`CCDC_MR_BYTE];
	wire        stream = cmd_r[`CCDC_C_TTYP] == `CCDC_TT_STRM;
	wire [5:0]  w      = sdw_r ? 6'd4 : 6'd1;
	wire [5:0]  ublen  = byte_m ? 6'd8 : 6'd32;
	wire [5:0]  ub_nx  = ub_r + w;
	wire [19:0] bc_nx  = bc_r + {14'h0000, w};
	wire [19:0] blk_b  = {1'b0, mr_r[`CCDC_MR_BLEN], 3'b000};
	wire        blk_last = ~stream & (bc_nx == blk_b);
	wire [3:0]  lm     = sdw_r ? 4'hf : 4'h1;
	wire [3:0]  txb    = sdw_r ? dsh_r[31:28] : {3'b000, dsh_r[31]};
	wire [31:0] rxw    = sdw_r ? {dsh_r[27:0], DAT_IN}
		: {dsh_r[30:0], DAT_IN[0]};
	wire [31:0] txw    = byte_m ? {tdr_r[7:0], 24'h000000} : tdr_r;
	wire [31:0] tsh_nx = sdw_r ? {dsh_r[27:0], 4'h0}
		: {dsh_r[30:0], 1'b0};
	wire        all_done = (cmd_r[`CCDC_C_TTYP] == `CCDC_TT_ONE)
		| ((block_count_field_r != 16'h0000) & (nb_r + 16'h0001 == block_count_field_r));

	// card clock
	wire [7:0] pmax  = 8'h01 << mr_r[`CCDC_MR_PSDIV];
	wire       stall = (mr_r[`CCDC_MR_RDG] & (dst_r == D_RX) & rx_full_r)
		| (mr_r[`CCDC_MR_WRG] & (dst_r == D_TX) & ~tx_full_r
		& (ub_nx == ublen) & ~blk_last);

	always @(posedge REF_CLK) begin
		if (rst | ~en_r) begin
			CARD_CLK <= 1'b0;
			hc_r     <= 8'h00;
			ps_r     <= 8'h00;
			rise_r   <= 1'b0;
			fall_r   <= 1'b0;
		end else begin
			rise_r <= 1'b0;
			fall_r <= 1'b0;
			if (hc_r != mr_r[`CCDC_MR_DIV]) begin
				hc_r <= hc_r + 8'h01;
			end else if (idle & pws_r & (ps_r != pmax)) begin
				hc_r <= 8'h00;
				ps_r <= ps_r + 8'h01;
			end else if (~CARD_CLK & stall) begin
				hc_r <= hc_r;
			end else begin
				hc_r     <= 8'h00;
				ps_r     <= 8'h00;
				CARD_CLK <= ~CARD_CLK;
				rise_r   <= ~CARD_CLK;
				fall_r   <= CARD_CLK;
			end
		end
	end

	// software registers
	always @(posedge REF_CLK) begin
		if (rst) begin
			en_r   <= 1'b0;
			pws_r  <= 1'b0;
			sdw_r  <= 1'b0;
			mr_r   <= `CCDC_MR_RST;
			arg_r  <= 32'h00000000;
			block_count_field_r <= 16'h0000;
		end else if (wr_cr) begin
			if (REG_WDATA[`CCDC_CR_DIS])
				en_r <= 1'b0;
			else if (REG_WDATA[`CCDC_CR_EN])
				en_r <= 1'b1;
			if (REG_WDATA[`CCDC_CR_PSDIS])
				pws_r <= 1'b0;
			else if (REG_WDATA[`CCDC_CR_PSEN])
				pws_r <= 1'b1;
		end else if (REG_WR & (REG_ADDR == `CCDC_A_MR)) begin
			mr_r <= REG_WDATA;
		end else if (REG_WR & (REG_ADDR == `CCDC_A_SDCR)) begin
			sdw_r <= REG_WDATA[`CCDC_SDCR_WIDE];
		end else if (REG_WR & (REG_ADDR == `CCDC_A_ARGR)) begin
			arg_r <= REG_WDATA;
		end else if (REG_WR & (REG_ADDR == `CCDC_A_BLKR)) begin
			block_count_field_r                <= REG_WDATA[`CCDC_BLK_CNT];
			mr_r[`CCDC_MR_BLEN] <= REG_WDATA[`CCDC_BLK_LEN];
		end
	end

	// command and response engine
	wire       r136 = cmd_r[`CCDC_C_RSP] == `CCDC_RSP_136;
	wire [7:0] rlen = r136 ? `CCDC_R136_LEN : `CCDC_R48_LEN;
	wire [6:0] lmax = cmd_r[`CCDC_C_LAT] ? `CCDC_LAT_LONG : `CCDC_LAT_STD;
	wire       rwin = r136 ? ((cc_r >= `CCDC_R136_LO) & (cc_r < `CCDC_R136_HI))
		: (cc_r < `CCDC_CMD_CRC);
	wire [135:0] rfull = {rsh_r[134:0], CMD_IN};
	wire       tb = (cc_r < `CCDC_CMD_CRC) ? tsh_r[47]
		: ((cc_r < `CCDC_CMD_END) ? c7_r[6] : 1'b1);

	always @(posedge REF_CLK) begin
		if (rst) begin
			cst_r   <= C_IDLE;
			cmd_r   <= 21'h000000;
			tsh_r   <= 48'h000000000000;
			cc_r    <= 8'h00;
			c7_r    <= 7'h00;
			lat_r   <= 7'h00;
			rsh_r   <= {136{1'b0}};
			rsp_r   <= {128{1'b0}};
			done_r  <= 1'b1;
			rto_r   <= 1'b0;
			rce_r   <= 1'b0;
			cfin_r  <= 1'b0;
			CMD_OUT <= 1'b1;
			CMD_OE  <= 1'b0;
		end else begin
			cfin_r <= 1'b0;
			if (sr_rd) begin
				rto_r <= 1'b0;
				rce_r <= 1'b0;
			end
			case (cst_r)
			C_IDLE: if (cmd_go) begin
				cmd_r  <= REG_WDATA[20:0];
				tsh_r  <= {2'b01, REG_WDATA[`CCDC_C_IDX], arg_r, 8'h00};
				cc_r   <= 8'h00;
				c7_r   <= 7'h00;
				done_r <= 1'b0;
				cst_r  <= C_TX;
			end
			C_TX: if (rise_r) begin
				CMD_OUT <= tb;
				CMD_OE  <= cmd_r[`CCDC_C_OD] ? ~tb : 1'b1;
				cc_r    <= cc_r + 8'h01;
				if (cc_r < `CCDC_CMD_CRC) begin
					c7_r  <= crc7(c7_r, tb);
					tsh_r <= {tsh_r[46:0], 1'b0};
				end else if (cc_r < `CCDC_CMD_END) begin
					c7_r <= {c7_r[5:0], 1'b0};
				end
				if (cc_r == `CCDC_CMD_LEN) begin
					CMD_OUT <= 1'b1;
					CMD_OE  <= 1'b0;
					lat_r   <= 7'h00;
					cc_r    <= 8'h00;
					if (cmd_r[`CCDC_C_RSP] == `CCDC_RSP_NONE) begin
						done_r <= 1'b1;
						cfin_r <= 1'b1;
						cst_r  <= C_IDLE;
					end else begin
						cst_r <= C_WAIT;
					end
				end
			end
			C_WAIT: if (fall_r) begin
				if (~CMD_IN) begin
					rsh_r <= rfull;
					cc_r  <= 8'h01;
					c7_r  <= 7'h00;
					cst_r <= C_RX;
				end else if (lat_r == lmax) begin
					rto_r  <= 1'b1;
					done_r <= 1'b1;
					cfin_r <= 1'b1;
					cst_r  <= C_IDLE;
				end else begin
					lat_r <= lat_r + 7'h01;
				end
			end
			default: if (fall_r) begin
				rsh_r <= rfull;
				cc_r  <= cc_r + 8'h01;
				if (rwin)
					c7_r <= crc7(c7_r, CMD_IN);
				if (cc_r + 8'h01 == rlen) begin
					rsp_r  <= r136 ? rfull[127:0]
						: {rfull[39:8], 96'h0};
					rce_r  <= (rsh_r[6:0] != c7_r) | rce_r;
					done_r <= 1'b1;
					cfin_r <= 1'b1;
					cst_r  <= C_IDLE;
				end
			end
			endcase
		end
	end

	// per-lane data CRC
	wire c_clr = (dst_r == D_IDLE) | (dst_r == D_WAIT) | (dst_r == D_TXS);
	wire c_upd = (fall_r & ((dst_r == D_RX)
		| ((dst_r == D_RCRC) & (dc_r < `CCDC_CRC16_N))))
		| (rise_r & (dst_r == D_TX));
	wire c_shf = rise_r & (dst_r == D_TCRC) & (dc_r < `CCDC_CRC16_N);
	wire [3:0] c_in = (dst_r == D_TX) ? txb : DAT_IN;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			reg [15:0] c_r;
			always @(posedge REF_CLK) begin
				if (rst | c_clr)
					c_r <= 16'h0000;
				else if (c_upd)
					c_r <= crc16(c_r, c_in[g]);
				else if (c_shf)
					c_r <= {c_r[14:0], 1'b0};
			end
			assign cz[g] = c_r == 16'h0000;
			assign cm[g] = c_r[15];
		end
	endgenerate

	// data transfer engine
	always @(posedge REF_CLK) begin
		if (rst) begin
			dst_r      <= D_IDLE;
			bc_r       <= 20'h00000;
			ub_r       <= 6'h00;
			nb_r       <= 16'h0000;
			dc_r       <= 5'h00;
			dsh_r      <= 32'h00000000;
			rdr_r      <= 32'h00000000;
			tdr_r      <= 32'h00000000;
			rx_full_r  <= 1'b0;
			tx_full_r  <= 1'b0;
			xdone_r    <= 1'b0;
			dce_r      <= 1'b0;
			DAT_OUT    <= 4'hf;
			DAT_OE     <= 4'h0;
			DMA_RX_REQ <= 1'b0;
			DMA_TX_REQ <= 1'b0;
		end else begin
			DMA_RX_REQ <= 1'b0;
			DMA_TX_REQ <= 1'b0;
			if (sr_rd) begin
				xdone_r <= 1'b0;
				dce_r   <= 1'b0;
			end
			if (rd_rdr)
				rx_full_r <= 1'b0;
			if (cfin_r) begin
				if (cmd_r[`CCDC_C_TRC] == `CCDC_TRC_STOP) begin
					dst_r   <= D_IDLE;
					DAT_OE  <= 4'h0;
					xdone_r <= 1'b1;
				end else if ((cmd_r[`CCDC_C_TRC] == `CCDC_TRC_GO) & ~rto_r) begin
					nb_r  <= 16'h0000;
					dst_r <= cmd_r[`CCDC_C_TDIR] ? D_WAIT : D_TXS;
				end
			end else begin
				case (dst_r)
				D_WAIT: if (fall_r & ~DAT_IN[0]) begin
					bc_r  <= 20'h00000;
					ub_r  <= 6'h00;
					dst_r <= D_RX;
				end
				D_RX: if (fall_r) begin
					dsh_r <= rxw;
					bc_r  <= bc_nx;
					ub_r  <= ub_nx;
					if (ub_nx == ublen) begin
						ub_r       <= 6'h00;
						rdr_r      <= byte_m ? {24'h000000, rxw[7:0]} : rxw;
						rx_full_r  <= 1'b1;
						DMA_RX_REQ <= mr_r[`CCDC_MR_DMA];
					end
					if (blk_last) begin
						dc_r  <= 5'h00;
						dst_r <= D_RCRC;
					end
				end
				D_RCRC: if (fall_r) begin
					dc_r <= dc_r + 5'h01;
					if (dc_r == `CCDC_CRC16_N) begin
						dce_r <= dce_r | (|(~cz & lm));
						nb_r  <= nb_r + 16'h0001;
						if (all_done) begin
							xdone_r <= 1'b1;
							dst_r   <= D_IDLE;
						end else begin
							dst_r <= D_WAIT;
						end
					end
				end
				D_TXS: if (rise_r & tx_full_r) begin
					DAT_OUT    <= 4'h0;
					DAT_OE     <= lm;
					dsh_r      <= txw;
					tx_full_r  <= 1'b0;
					DMA_TX_REQ <= mr_r[`CCDC_MR_DMA];
					bc_r       <= 20'h00000;
					ub_r       <= 6'h00;
					dst_r      <= D_TX;
				end
				D_TX: if (rise_r) begin
					DAT_OUT <= txb;
					dsh_r   <= tsh_nx;
					bc_r    <= bc_nx;
					ub_r    <= ub_nx;
					if ((ub_nx == ublen) & ~blk_last) begin
						ub_r       <= 6'h00;
						dsh_r      <= txw;
						tx_full_r  <= 1'b0;
						DMA_TX_REQ <= mr_r[`CCDC_MR_DMA];
					end
					if (blk_last) begin
						dc_r  <= 5'h00;
						dst_r <= D_TCRC;
					end
				end
				D_TCRC: if (rise_r) begin
					dc_r <= dc_r + 5'h01;
					if (dc_r < `CCDC_CRC16_N) begin
						DAT_OUT <= cm;
					end else if (dc_r == `CCDC_CRC16_N) begin
						DAT_OUT <= 4'hf;
					end else begin
						DAT_OE <= 4'h0;
						dc_r   <= 5'h00;
						dst_r  <= D_BUSY;
					end
				end
				D_BUSY: if (fall_r) begin
					if (dc_r != `CCDC_BUSY_GAP) begin
						dc_r <= dc_r + 5'h01;
					end else if (DAT_IN[0]) begin
						nb_r <= nb_r + 16'h0001;
						if (all_done) begin
							xdone_r <= 1'b1;
							dst_r   <= D_IDLE;
						end else begin
							dst_r <= D_TXS;
						end
					end
				end
				default: ;
				endcase
			end
			if (wr_tdr) begin
				tdr_r     <= REG_WDATA;
				tx_full_r <= 1'b1;
			end
		end
	end

	// status and read-back
	always @* begin
		sr_v                  = 32'h00000000;
		sr_v[`CCDC_SR_CDONE] = done_r;
		sr_v[`CCDC_SR_RXRDY] = rx_full_r;
		sr_v[`CCDC_SR_TXRDY] = ~tx_full_r;
		sr_v[`CCDC_SR_DIDLE] = dst_r == D_IDLE;
		sr_v[`CCDC_SR_XDONE] = xdone_r;
		sr_v[`CCDC_SR_RTO]   = rto_r;
		sr_v[`CCDC_SR_RCE]   = rce_r;
		sr_v[`CCDC_SR_DCE]   = dce_r;
	end

	always @* begin
		rd_v = 32'h00000000;
		if (REG_ADDR == `CCDC_A_MR)
			rd_v = mr_r;
		else if (REG_ADDR == `CCDC_A_SDCR)
			rd_v = {31'h00000000, sdw_r};
		else if (REG_ADDR == `CCDC_A_ARGR)
			rd_v = arg_r;
		else if (REG_ADDR == `CCDC_A_BLKR)
			rd_v = {mr_r[`CCDC_MR_BLEN], block_count_field_r};
		else if (REG_ADDR == `CCDC_A_RSP0)
			rd_v = rsp_r[127:96];
		else if (REG_ADDR == `CCDC_A_RSP1)
			rd_v = rsp_r[95:64];
		else if (REG_ADDR == `CCDC_A_RSP2)
			rd_v = rsp_r[63:32];
		else if (REG_ADDR == `CCDC_A_RSP3)
			rd_v = rsp_r[31:0];
		else if (REG_ADDR == `CCDC_A_RDR)
			rd_v = rdr_r;
		else if (REG_ADDR == `CCDC_A_SR)
			rd_v = sr_v;
	end

	always @(posedge REF_CLK) begin
		if (rst)
			REG_RDATA <= 32'h00000000;
		else
			REG_RDATA <= REG_RD ? rd_v : 32'h00000000;
	end
endmodule // ccdc_top

// ### ccdc_top_assertions.sv
// Purpose: port checks of the card controller
// Assumes: no disable, soft reset or command while busy
// Notes: mode shadows follow register writes
`include "ccdc_regs.vh"
module ccdc_chk (
	// system
	input wire        REF_CLK,
	input wire        RST_B,
	// register port
	input wire [7:0]  REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire        REG_WR,
	input wire        REG_RD,
	input wire [31:0] REG_RDATA,
	// card bus
	input wire        CARD_CLK,
	input wire        CMD_IN,
	input wire        CMD_OUT,
	input wire        CMD_OE,
	input wire [3:0]  DAT_IN,
	input wire [3:0]  DAT_OUT,
	input wire [3:0]  DAT_OE,
	// dma
	input wire        DMA_RX_REQ,
	input wire        DMA_TX_REQ
);
	reg  en_r;
	reg  od_r;
	reg  dma_r;
	reg  wide_r;
	wire cr_w = REG_WR && REG_ADDR == `CCDC_A_CR;
	always @(posedge REF_CLK) begin
		if (!RST_B) begin
			en_r <= 1'b0;
			od_r <= 1'b0;
			dma_r <= 1'b0;
			wide_r <= 1'b0;
		end else if (REG_WR) begin
			if (cr_w && REG_WDATA[1:0] == 2'h1)
				en_r <= 1'b1;
			if (cr_w && REG_WDATA[1])
				en_r <= 1'b0;
			if (REG_ADDR == `CCDC_A_CMDR)
				od_r <= REG_WDATA[11];
			if (REG_ADDR == `CCDC_A_MR)
				dma_r <= REG_WDATA[15];
			if (REG_ADDR == `CCDC_A_SDCR)
				wide_r <= REG_WDATA[0];
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	a_clk_held: assert property (!en_r |-> !CARD_CLK)
		else $error("card clock runs while disabled");
	a_pins_quiet: assert property (!en_r |-> !CMD_OE && DAT_OE == 4'h0)
		else $error("bus driven while disabled");
	a_cmd_on_rise: assert property (($changed(CMD_OUT) || $changed(CMD_OE))
		|-> $past(CARD_CLK) && !$past(CARD_CLK, 2))
		else $error("command line moved off a card clock rise");
	a_od_low_only: assert property (od_r && CMD_OE |-> !CMD_OUT)
		else $error("open drain command drove high");
	a_cmd_starts: assert property (en_r && REG_WR && REG_ADDR == `CCDC_A_CMDR
		|-> ##[1:20] CMD_OE && !CMD_OUT)
		else $error("command start bit late");
	a_dma_gated: assert property (!dma_r |-> !DMA_RX_REQ && !DMA_TX_REQ)
		else $error("dma request outside dma mode");
	a_rx_pulse: assert property (DMA_RX_REQ |=> !DMA_RX_REQ)
		else $error("receive request longer than one cycle");
	a_narrow_bus: assert property (!wide_r |-> DAT_OE[3:1] == 3'h0)
		else $error("upper data lanes driven in one-bit mode");
endmodule // ccdc_chk

bind ccdc_top ccdc_chk chk_u (
	.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .CARD_CLK(CARD_CLK), .CMD_IN(CMD_IN),
	.CMD_OUT(CMD_OUT), .CMD_OE(CMD_OE), .DAT_IN(DAT_IN),
	.DAT_OUT(DAT_OUT), .DAT_OE(DAT_OE), .DMA_RX_REQ(DMA_RX_REQ),
	.DMA_TX_REQ(DMA_TX_REQ)
);

// ### ccdc_card.sv
// Purpose: card model answering commands and sending one read block
// Assumes: bench resolves lines with pull-ups
// Notes: bits launched 1 ns after the card clock rises
module ccdc_card (
	// card bus
	input  wire        clk,
	input  wire        cmd,
	output reg         c_oe,
	output reg         c_o,
	output reg         d_oe,
	output reg         d_o,
	// bench control
	input  wire [1:0]  kind,
	input  wire        bad,
	input  wire        rd_blk,
	output reg  [47:0] got
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam [31:0] BLK = 32'hc3a5_0f96;
	reg [135:0] r;
	reg [15:0]  c;
	integer     i;
	integer     n;
	initial begin
		c_oe = 1'b0;
		c_o = 1'b1;
		d_oe = 1'b0;
		d_o = 1'b1;
		got = 48'h0;
		forever begin
			@(posedge clk);
			if (cmd === 1'b0) begin
				for (i = 46; i >= 0; i = i - 1) begin
					@(posedge clk);
					got[i] = cmd;
				end
				got[47] = 1'b0;
				if (kind != 2'd0) begin
					n = kind == 2'd2 ? 136 : 48;
					if (n == 48)
						r = {88'h0, 2'b00, got[45:40], ~got[39:8], 8'h01};
					else
						r = {8'h3f, got[39:8], ~got[39:8], got[23:8],
							got[39:24], got[39:16] ^ 24'h0f0f0f, 8'h01};
					c = 16'h0;
					for (i = n == 48 ? 47 : 127; i >= 8; i = i - 1)
						c[6:0] = {c[5:0], 1'b0} ^ ((c[6] ^ r[i]) ? 7'h09 : 7'h00);
					r[7:1] = c[6:0] ^ {6'h0, bad};
					repeat (2) @(posedge clk);
					#1;
					c_oe = 1'b1;
					for (i = n - 1; i >= 0; i = i - 1) begin
						c_o = r[i];
						@(posedge clk);
						#1;
					end
					c_oe = 1'b0;
					if (rd_blk) begin
						c = 16'h0;
						for (i = 31; i >= 0; i = i - 1)
							c = {c[14:0], 1'b0} ^ ((c[15] ^ BLK[i]) ? 16'h1021 : 16'h0);
						r = {86'h0, 1'b0, BLK, c, 1'b1};
						repeat (2) @(posedge clk);
						#1;
						d_oe = 1'b1;
						for (i = 49; i >= 0; i = i - 1) begin
							d_o = r[i];
							@(posedge clk);
							#1;
						end
						d_oe = 1'b0;
					end
				end
			end
		end
	end
endmodule // ccdc_card

// ### ccdc_top_tb.sv
// Purpose: self-checking bench of the card controller
// Assumes: one card model; command and data lines pulled up
// Notes: card clock half period is two reference cycles
`include "ccdc_regs.vh"
module ccdc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg         ref_clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [31:0] reg_wdata = 32'h0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [1:0]  kind = 2'd0;
	reg         bad = 1'b0;
	reg         rd_blk = 1'b0;
	wire [31:0] reg_rdata;
	wire        card_clk;
	wire        cmd_out;
	wire        cmd_oe;
	wire [3:0]  dat_out;
	wire [3:0]  dat_oe;
	wire        rx_req;
	wire        tx_req;
	reg  [49:0] tx_sh = 50'h0;
	integer     tx_n = 0;
	wire        c_oe;
	wire        c_o;
	wire        d_oe;
	wire        d_o;
	wire [47:0] got;
	wire        cmd_line = ~((cmd_oe & ~cmd_out) | (c_oe & ~c_o));
	wire [3:0]  dat_line = ~((dat_oe & ~dat_out) | {3'h0, d_oe & ~d_o});
	integer     fails = 0;
	integer     check_count = 0;
	integer     cyc = 0;
	integer     rises = 0;
	integer     rx_n = 0;
	always #10 ref_clk = ~ref_clk;
	always @(posedge card_clk) rises = rises + 1;
	// lane 0 frame as the card sees it: start, data, crc, end
	always @(posedge card_clk)
		if (dat_oe[0] === 1'b1)
			tx_sh <= {tx_sh[48:0], dat_out[0]};
	ccdc_top dut_u (
		.REF_CLK(ref_clk), .RST_B(rst_b), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .CARD_CLK(card_clk), .CMD_IN(cmd_line),
		.CMD_OUT(cmd_out), .CMD_OE(cmd_oe), .DAT_IN(dat_line),
		.DAT_OUT(dat_out), .DAT_OE(dat_oe), .DMA_RX_REQ(rx_req),
		.DMA_TX_REQ(tx_req)
	);
	ccdc_card card_u (
		.clk(card_clk), .cmd(cmd_line), .c_oe(c_oe), .c_o(c_o),
		.d_oe(d_oe), .d_o(d_o), .kind(kind), .bad(bad),
		.rd_blk(rd_blk), .got(got)
	);
	task final_report;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (rx_req === 1'b1)
			rx_n = rx_n + 1;
		if (tx_req === 1'b1)
			tx_n = tx_n + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			final_report;
		end
	end
	task automatic chk(input [31:0] seen, input [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, output [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	// polls status, gathering flags that clear on read
	task automatic wait_sr(input integer b, output [31:0] acc);
		reg [31:0] s;
		integer    k;
		acc = 32'h0;
		for (k = 0; k < 900 && !acc[b]; k = k + 1) begin
			rd(`CCDC_A_SR, s);
			acc = acc | s;
		end
		chk({31'd0, acc[b]}, 32'h1);
	endtask
	function automatic [6:0] crc7(input [39:0] v);
		integer j;
		crc7 = 7'h00;
		for (j = 39; j >= 0; j = j - 1)
			crc7 = {crc7[5:0], 1'b0} ^ ((crc7[6] ^ v[j]) ? 7'h09 : 7'h00);
	endfunction
	function automatic [15:0] crc16(input [31:0] v);
		integer j;
		crc16 = 16'h0000;
		for (j = 31; j >= 0; j = j - 1)
			crc16 = {crc16[14:0], 1'b0}
				^ ((crc16[15] ^ v[j]) ? 16'h1021 : 16'h0000);
	endfunction
	task automatic t_reset;
		reg [31:0] v;
		rd(`CCDC_A_SR, v);
		chk(v, 32'h0000_0015);
		rd(`CCDC_A_MR, v);
		chk(v, 32'h0);
		rd(8'h1c, v);
		chk(v, 32'h0);
		rises = 0;
		wr(`CCDC_A_CMDR, 32'h0000_0041);
		repeat (40) @(posedge ref_clk);
		chk(rises, 32'h0);
		rd(`CCDC_A_SR, v);
		chk(v, 32'h0000_0015);
	endtask
	task automatic t_cmd48;
		reg [31:0] v;
		reg [31:0] a;
		integer    b;
		wr(`CCDC_A_MR, 32'h0004_0001);
		wr(`CCDC_A_CR, 32'h1);
		kind = 2'd1;
		for (b = 0; b < 2; b = b + 1) begin
			a = 32'h1234_5678 + b;
			bad = b[0];
			wr(`CCDC_A_ARGR, a);
			wr(`CCDC_A_CMDR, 32'h0000_004d);
			wait_sr(0, v);
			chk(v & 32'h0003_0001, {14'd0, b[0], 17'h1});
			chk({24'd0, got[47:40]}, 32'h4d);
			chk(got[39:8], a);
			chk({25'd0, got[7:1]}, {25'd0, crc7({8'h4d, a})});
			chk({31'd0, got[0]}, 32'h1);
			rd(`CCDC_A_RSP0, v);
			chk(v, ~a);
			rd(`CCDC_A_RSP1, v);
			chk(v, 32'h0);
		end
		bad = 1'b0;
	endtask
	task automatic t_long;
		reg [31:0] v;
		reg [31:0] a;
		reg [31:0] e [0:3];
		integer    k;
		a = 32'h8e31_47a6;
		e[0] = a;
		e[1] = ~a;
		e[2] = {a[15:0], a[31:16]};
		e[3] = (a ^ 32'h0f0f_0f0f) & 32'hffff_ff00;
		kind = 2'd2;
		wr(`CCDC_A_ARGR, a);
		wr(`CCDC_A_CMDR, 32'h0000_0882);
		wait_sr(0, v);
		chk(v & 32'h0003_0001, 32'h1);
		for (k = 0; k < 4; k = k + 1) begin
			rd(`CCDC_A_RSP0 + {k[5:0], 2'b00}, v);
			chk(k == 3 ? v & 32'hffff_ff00 : v, e[k]);
		end
	endtask
	task automatic t_timeout;
		reg [31:0] v;
		integer    l;
		integer    lo;
		kind = 2'd0;
		for (l = 0; l < 2; l = l + 1) begin
			lo = (l ? 64 : 5) + 45;
			rises = 0;
			wr(`CCDC_A_CMDR, l ? 32'h0000_1041 : 32'h0000_0041);
			wait_sr(0, v);
			chk(v & 32'h0001_0001, 32'h0001_0001);
			chk({31'd0, rises >= lo && rises < lo + 12}, 32'h1);
		end
	endtask
	task automatic t_read;
		reg [31:0] v;
		integer    m;
		kind = 2'd1;
		rd_blk = 1'b1;
		for (m = 0; m < 2; m = m + 1) begin
			wr(`CCDC_A_MR, m ? 32'h0004_a001 : 32'h0004_8001);
			rx_n = 0;
			wr(`CCDC_A_CMDR, 32'h0005_0051);
			wait_sr(5, v);
			chk(v & 32'h0005_0021, 32'h21);
			chk(rx_n, m ? 32'h4 : 32'h1);
			rd(`CCDC_A_RDR, v);
			chk(v, m ? 32'h0000_0096 : 32'hc3a5_0f96);
		end
		rx_n = 0;
		wr(`CCDC_A_CMDR, 32'h0004_0051);
		wait_sr(0, v);
		repeat (300) @(posedge ref_clk);
		rd(`CCDC_A_SR, v);
		chk(v & 32'h22, 32'h0);
		chk(rx_n, 32'h0);
		rd_blk = 1'b0;
	endtask
	task automatic t_write;
		reg [31:0] v;
		reg [31:0] d;
		d = 32'h5a3c_e187;
		kind = 2'd1;
		tx_n = 0;
		wr(`CCDC_A_MR, 32'h0004_8001);
		wr(`CCDC_A_TDR, d);
		wr(`CCDC_A_CMDR, 32'h0001_0051);
		wait_sr(5, v);
		chk(v & 32'h0004_0021, 32'h21);
		chk(tx_n, 32'h1);
		chk(tx_sh[48:17], d);
		chk({16'h0, tx_sh[16:1]}, {16'h0, crc16(d)});
		chk({30'h0, tx_sh[49], tx_sh[0]}, 32'h1);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset;
		t_cmd48;
		t_long;
		t_timeout;
		t_read;
		t_write;
		final_report;
	end
endmodule // ccdc_top_tb
